// [src/code_regs.sv]
// Volatile code registers, one per channel, all readable in parallel.
// Assumes one write port on the block clock; values are unsigned binary.
`timescale 1ns/100ps
module code_regs
    import dac_ctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire code_t wr_data,
    output code_t [NUM_CH-1:0] codes_ff
);
    // ==========================================================
    // Storage
    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_entry
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    codes_ff[i] <= CODE_RST;
                end else if (wr_en && (wr_idx == 3'(i))) begin
                    codes_ff[i] <= wr_data;
                end
            end
        end
    endgenerate
endmodule : code_regs

// [src/dac_ctl_pkg.sv]
// Constants, codes and carrier types for the converter latch and sleep control.
// Assumes a single 100 MHz clock and the plain register port of the top module.
// Contract
// - Gate high: hold outputs, still accept code writes
// - Gate low: copy code registers to outputs
// - Level driven: outputs follow writes while low
// - Gate pin is asynchronous; accept it anytime
// - Channels sharing one gate update together
// - Each channel has its own sleep setting
// - Sleep modes power down, output high impedance
// - Sleep keeps code and configuration unchanged
// - Sleep code: normal, 1k, 100k, open
// - Entry delay before output stops, pulldown engages
// - Amp, buffer, band gap powered per mode/reference
// - Ladder draws supply only normal, reference not 10
// - Sleep bits change by write or reset load
// - Writing 00 wakes channel, drops pulldown
// - Exit delay before amplifier drives again
// - Code registers hold unsigned binary values
package dac_ctl_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_CH = 8;
    localparam int NUM_GATES = 2;
    localparam int CH_PER_GATE = 4;
    localparam int CODE_W = 12;
    localparam int CNT_W = 16;
    // ==========================================================
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] CODE_BASE_OFS = 8'h00;
    localparam logic [7:0] SLEEP_VOL_OFS = 8'h20;
    localparam logic [7:0] SLEEP_NV_OFS = 8'h24;
    localparam logic [7:0] REF_SEL_OFS = 8'h28;
    localparam logic [7:0] ENTRY_DLY_OFS = 8'h2C;
    localparam logic [7:0] EXIT_DLY_OFS = 8'h30;
    localparam logic [7:0] STATUS_OFS = 8'h34;
    localparam logic [7:0] WIPER_BASE_OFS = 8'h40;
    // ==========================================================
    // Status field positions
    localparam int ST_DRIVE_LSB = 0;
    localparam int ST_GATE_LSB = 8;
    localparam int ST_ASLEEP_LSB = 16;
    // ==========================================================
    // Reset values
    localparam logic [15:0] SLEEP_NV_RST = 16'h0000;
    localparam logic [15:0] REF_SEL_RST = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ENTRY_DELAY_NS = 1000;
    localparam int EXIT_DELAY_NS = 5000;
    localparam logic [CNT_W-1:0] ENTRY_CYC_RST =
        CNT_W'((ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] EXIT_CYC_RST =
        CNT_W'((EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // ==========================================================
    // Codes
    localparam logic [1:0] SLEEP_NORMAL = 2'h0;
    localparam logic [1:0] SLEEP_1K = 2'h1;
    localparam logic [1:0] SLEEP_100K = 2'h2;
    localparam logic [1:0] SLEEP_OPEN = 2'h3;
    localparam logic [1:0] REF_BANDGAP = 2'h1;
    localparam logic [1:0] REF_EXT_UNBUF = 2'h2;
    typedef enum logic [1:0] {
        SEQ_ACTIVE = 2'b00,
        SEQ_ENTER = 2'b01,
        SEQ_ASLEEP = 2'b10,
        SEQ_WAKE = 2'b11
    } seq_state_t;
    // ==========================================================
    // Carriers
    typedef logic [CODE_W-1:0] code_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic drive;
        logic pd_1k;
        logic pd_100k;
        logic amp_pwr;
        logic ladder_pwr;
        logic refbuf_pwr;
        logic bandgap_pwr;
    } chan_ctrl_t;
endpackage : dac_ctl_pkg

// [src/dac_latch_ctl.sv]
// Top of the latch and sleep control: register port, gate synchronisers,
// output stage registers and per-channel sleep sequencing.
// Assumes gate pins are asynchronous and the register master is on mclk.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module dac_latch_ctl
    import dac_ctl_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire reg_req_t reg_req,
    output logic [31:0] rdata_ff,
    input wire logic [NUM_GATES-1:0] group_update_gate_n,
    output code_t [NUM_CH-1:0] wiper_ff,
    output chan_ctrl_t [NUM_CH-1:0] chan_ctrl_ff
);
    // ==========================================================
    // Reset release
    logic rst_meta_ff;
    logic rst_sync_ff;
    wire rst_n = rst_sync_ff;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ==========================================================
    // Register decode
    wire [7:0] addr = reg_req.addr;
    wire word_ok = (addr[1:0] == 2'b00);
    wire in_code = word_ok && (addr[7:5] == CODE_BASE_OFS[7:5]);
    wire in_wiper = word_ok && (addr[7:5] == WIPER_BASE_OFS[7:5]);
    wire [2:0] ch_idx = addr[4:2];
    wire wr_code = reg_req.wr && in_code;
    wire wr_sleep_vol = reg_req.wr && (addr == SLEEP_VOL_OFS);
    wire wr_sleep_nv = reg_req.wr && (addr == SLEEP_NV_OFS);
    wire wr_ref = reg_req.wr && (addr == REF_SEL_OFS);
    wire wr_entry = reg_req.wr && (addr == ENTRY_DLY_OFS);
    wire wr_exit = reg_req.wr && (addr == EXIT_DLY_OFS);

    // ==========================================================
    // Configuration registers
    logic [15:0] sleep_vol_ff;
    logic [15:0] sleep_nv_ff;
    logic [15:0] ref_sel_ff;
    logic [CNT_W-1:0] entry_ff;
    logic [CNT_W-1:0] exit_ff;
    logic load_pending_ff;

    // Sleep bits start from the stored copy one edge after release,
    // since an async reset may only load a constant.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            load_pending_ff <= 1'b1;
            sleep_vol_ff <= 16'h0000;
        end else if (load_pending_ff) begin
            load_pending_ff <= 1'b0;
            sleep_vol_ff <= sleep_nv_ff;
        end else if (wr_sleep_vol) begin
            sleep_vol_ff <= reg_req.wdata[15:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_nv_ff <= SLEEP_NV_RST;
            ref_sel_ff <= REF_SEL_RST;
            entry_ff <= ENTRY_CYC_RST;
            exit_ff <= EXIT_CYC_RST;
        end else begin
            if (wr_sleep_nv) begin
                sleep_nv_ff <= reg_req.wdata[15:0];
            end
            if (wr_ref) begin
                ref_sel_ff <= reg_req.wdata[15:0];
            end
            if (wr_entry) begin
                entry_ff <= reg_req.wdata[CNT_W-1:0];
            end
            if (wr_exit) begin
                exit_ff <= reg_req.wdata[CNT_W-1:0];
            end
        end
    end

    // ==========================================================
    // Code registers; sleep never touches them
    code_t [NUM_CH-1:0] codes;

    code_regs u_code_regs (
        .clk(mclk),
        .rst_n(rst_n),
        .wr_en(wr_code),
        .wr_idx(ch_idx),
        .wr_data(reg_req.wdata[CODE_W-1:0]),
        .codes_ff(codes)
    );

    // ==========================================================
    // Gate pin synchronisers
    logic [NUM_GATES-1:0] gate_meta_ff;
    logic [NUM_GATES-1:0] gate_s2_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gate_meta_ff <= '1;
            gate_s2_ff <= '1;
        end else begin
            gate_meta_ff <= group_update_gate_n;
            gate_s2_ff <= gate_meta_ff;
        end
    end

    // ==========================================================
    // Per-channel output stage and sleep control
    logic [NUM_CH-1:0] seq_drive;
    logic [1:0] seq_pd [NUM_CH];
    logic [NUM_CH-1:0] seq_asleep;
    logic [1:0] sel_w [NUM_CH];
    logic [1:0] ref_w [NUM_CH];
    logic [NUM_CH-1:0] powered;
    logic [NUM_CH-1:0] gate_low;

    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_ch
            assign sel_w[c] = sleep_vol_ff[2*c +: 2];
            assign ref_w[c] = ref_sel_ff[2*c +: 2];
            // One synchronised level per group, so the group moves as one
            assign gate_low[c] = !gate_s2_ff[c / CH_PER_GATE];
            // Circuits stay up while the amplifier still drives on entry
            assign powered[c] = seq_drive[c] || (sel_w[c] == SLEEP_NORMAL);

            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    wiper_ff[c] <= CODE_RST;
                end else if (gate_low[c]) begin
                    wiper_ff[c] <= codes[c];
                end
            end

            sleep_seq u_seq (
                .clk(mclk),
                .rst_n(rst_n),
                .sleep_sel(sel_w[c]),
                .entry_cnt(entry_ff),
                .exit_cnt(exit_ff),
                .drive_ff(seq_drive[c]),
                .pd_sel_ff(seq_pd[c]),
                .asleep(seq_asleep[c])
            );

            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    chan_ctrl_ff[c] <= '0;
                end else begin
                    chan_ctrl_ff[c].drive <= seq_drive[c];
                    chan_ctrl_ff[c].pd_1k <= (seq_pd[c] == SLEEP_1K);
                    chan_ctrl_ff[c].pd_100k <= (seq_pd[c] == SLEEP_100K);
                    chan_ctrl_ff[c].amp_pwr <= powered[c];
                    chan_ctrl_ff[c].ladder_pwr <=
                        powered[c] && (ref_w[c] != REF_EXT_UNBUF);
                    chan_ctrl_ff[c].refbuf_pwr <= powered[c] && ref_w[c][0];
                    chan_ctrl_ff[c].bandgap_pwr <=
                        powered[c] && (ref_w[c] == REF_BANDGAP);
                end
            end
        end
    endgenerate

    // ==========================================================
    // Read path; unmapped addresses read zero
    logic [31:0] status_w;
    logic [NUM_CH-1:0] drive_w;

    generate
        for (c = 0; c < NUM_CH; c++) begin : g_st
            assign drive_w[c] = chan_ctrl_ff[c].drive;
        end
    endgenerate

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[ST_DRIVE_LSB +: NUM_CH] = drive_w;
        status_w[ST_GATE_LSB +: NUM_GATES] = gate_s2_ff;
        status_w[ST_ASLEEP_LSB +: NUM_CH] = seq_asleep;
    end

    wire [31:0] code_rd = {20'h00000, codes[ch_idx]};
    wire [31:0] wiper_rd = {20'h00000, wiper_ff[ch_idx]};
    wire [31:0] rd_mux =
        in_code ? code_rd :
        in_wiper ? wiper_rd :
        (addr == SLEEP_VOL_OFS) ? {16'h0000, sleep_vol_ff} :
        (addr == SLEEP_NV_OFS) ? {16'h0000, sleep_nv_ff} :
        (addr == REF_SEL_OFS) ? {16'h0000, ref_sel_ff} :
        (addr == ENTRY_DLY_OFS) ? {16'h0000, entry_ff} :
        (addr == EXIT_DLY_OFS) ? {16'h0000, exit_ff} :
        (addr == STATUS_OFS) ? status_w :
        32'h0000_0000;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= reg_req.rd ? rd_mux : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_sleep_hold;
        !wr_sleep_vol && !load_pending_ff |=> $stable(sleep_vol_ff);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("Sleep bits changed without a write");

    property p_code_hold;
        !wr_code |=> $stable(codes);
    endproperty
    a_code_hold: assert property (p_code_hold)
        else $error("Code register changed without a write");

    generate
        for (c = 0; c < NUM_CH; c++) begin : g_chk
            localparam int G = c / CH_PER_GATE;

            property p_gate_hold;
                gate_s2_ff[G] |=> $stable(wiper_ff[c]);
            endproperty
            a_gate_hold: assert property (p_gate_hold)
                else $error("Output moved while gate high");

            property p_gate_copy;
                !gate_s2_ff[G] |=> wiper_ff[c] == $past(codes[c]);
            endproperty
            a_gate_copy: assert property (p_gate_copy)
                else $error("Output not copied while gate low");

            property p_level_follow;
                (!gate_s2_ff[G] && wr_code && ch_idx == 3'(c)) ##1 !gate_s2_ff[G]
                    |=> wiper_ff[c] == $past(reg_req.wdata[CODE_W-1:0], 2);
            endproperty
            a_level_follow: assert property (p_level_follow)
                else $error("Output did not follow write while gate low");

            property p_sync;
                !group_update_gate_n[G] [*3] |-> !gate_s2_ff[G];
            endproperty
            a_sync: assert property (p_sync)
                else $error("Gate level not synchronised in two stages");

            property p_group;
                $changed(wiper_ff[c]) |-> $past(gate_low[c]);
            endproperty
            a_group: assert property (p_group)
                else $error("Output changed outside its group gate");

            property p_asleep_off;
                seq_asleep[c] |=> !chan_ctrl_ff[c].drive && !chan_ctrl_ff[c].amp_pwr
                    || $past(sel_w[c]) == SLEEP_NORMAL;
            endproperty
            a_asleep_off: assert property (p_asleep_off)
                else $error("Sleeping channel still driven");

            property p_pd_decode;
                chan_ctrl_ff[c].pd_1k |-> $past(seq_pd[c]) == SLEEP_1K
                    && !chan_ctrl_ff[c].pd_100k;
            endproperty
            a_pd_decode: assert property (p_pd_decode)
                else $error("Pulldown decode wrong");

            property p_entry_delay;
                (seq_drive[c] && sel_w[c] == SLEEP_NORMAL) ##1 sel_w[c] != SLEEP_NORMAL
                    |=> chan_ctrl_ff[c].drive [*2];
            endproperty
            a_entry_delay: assert property (p_entry_delay)
                else $error("Output dropped before entry delay");

            property p_bandgap;
                chan_ctrl_ff[c].bandgap_pwr |-> $past(ref_w[c]) == REF_BANDGAP;
            endproperty
            a_bandgap: assert property (p_bandgap)
                else $error("Band gap powered for wrong reference");

            property p_ladder;
                chan_ctrl_ff[c].ladder_pwr |-> $past(ref_w[c]) != REF_EXT_UNBUF
                    && $past(powered[c]);
            endproperty
            a_ladder: assert property (p_ladder)
                else $error("Ladder powered from supply wrongly");

            property p_wake_pd;
                sel_w[c] == SLEEP_NORMAL |-> ##2
                    !chan_ctrl_ff[c].pd_1k && !chan_ctrl_ff[c].pd_100k;
            endproperty
            a_wake_pd: assert property (p_wake_pd)
                else $error("Pulldown kept after wake");

            property p_wake_drive;
                $rose(chan_ctrl_ff[c].drive) |-> $past(sel_w[c], 2) == SLEEP_NORMAL;
            endproperty
            a_wake_drive: assert property (p_wake_drive)
                else $error("Drive resumed without normal mode");

            property p_refbuf;
                chan_ctrl_ff[c].refbuf_pwr |-> $past(ref_w[c][0]) && $past(powered[c]);
            endproperty
            a_refbuf: assert property (p_refbuf)
                else $error("Reference buffer powered for wrong reference");

            property p_open_mode;
                $past(seq_pd[c]) == SLEEP_OPEN |-> !chan_ctrl_ff[c].pd_1k
                    && !chan_ctrl_ff[c].pd_100k;
            endproperty
            a_open_mode: assert property (p_open_mode)
                else $error("Pulldown engaged in open mode");

            // Circuits return on the write of 00; only the drive waits
            property p_wake_power;
                sel_w[c] == SLEEP_NORMAL |=> chan_ctrl_ff[c].amp_pwr;
            endproperty
            a_wake_power: assert property (p_wake_power)
                else $error("Circuits not powered in normal mode");
        end
    endgenerate

    c_gate_release: cover property (gate_s2_ff[0] ##1 !gate_s2_ff[0]);
    c_enter_sleep: cover property ($rose(seq_asleep[0]));
    c_wake_done: cover property ($rose(chan_ctrl_ff[0].drive));
    c_group1_update: cover property (!gate_s2_ff[1] && $changed(wiper_ff[4]));
    c_entry_cancel: cover property ((sel_w[0] != SLEEP_NORMAL) ##1
        (sel_w[0] == SLEEP_NORMAL && seq_drive[0]));
endmodule : dac_latch_ctl

// [src/sleep_seq.sv]
// Per-channel sleep sequencer with entry and exit delays.
// Assumes sleep_sel comes from a register on the same clock.
`timescale 1ns/100ps
module sleep_seq
    import dac_ctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] sleep_sel,
    input wire logic [CNT_W-1:0] entry_cnt,
    input wire logic [CNT_W-1:0] exit_cnt,
    output logic drive_ff,
    output logic [1:0] pd_sel_ff,
    output logic asleep
);
    // ==========================================================
    // State
    seq_state_t state_ff;
    logic [CNT_W-1:0] cnt_ff;
    wire req_sleep = (sleep_sel != SLEEP_NORMAL);
    wire cnt_done = (cnt_ff == '0);
    assign asleep = (state_ff == SEQ_ASLEEP);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SEQ_ACTIVE;
            cnt_ff <= '0;
            drive_ff <= 1'b1;
            pd_sel_ff <= SLEEP_NORMAL;
        end else begin
            unique case (state_ff)
                SEQ_ACTIVE: begin
                    if (req_sleep) begin
                        state_ff <= SEQ_ENTER;
                        cnt_ff <= entry_cnt;
                    end
                end
                SEQ_ENTER: begin
                    if (!req_sleep) begin
                        state_ff <= SEQ_ACTIVE;
                    end else if (cnt_done) begin
                        state_ff <= SEQ_ASLEEP;
                        drive_ff <= 1'b0;
                        pd_sel_ff <= sleep_sel;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                SEQ_ASLEEP: begin
                    if (!req_sleep) begin
                        state_ff <= SEQ_WAKE;
                        cnt_ff <= exit_cnt;
                        pd_sel_ff <= SLEEP_NORMAL;
                    end else begin
                        pd_sel_ff <= sleep_sel;
                    end
                end
                SEQ_WAKE: begin
                    if (req_sleep) begin
                        state_ff <= SEQ_ASLEEP;
                        pd_sel_ff <= sleep_sel;
                    end else if (cnt_done) begin
                        state_ff <= SEQ_ACTIVE;
                        drive_ff <= 1'b1;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
            endcase
        end
    end
endmodule : sleep_seq

// [testbench/host_model.sv]
// ==========================================================
// Host side model: register master and group update gate drivers.
// Assumes the device samples requests on the rising edge of mclk.
`timescale 1ns/100ps
module host_model
    import dac_ctl_pkg::*;
(
    input wire logic mclk,
    output reg_req_t reg_req,
    input wire logic [31:0] rdata_ff,
    output logic [NUM_GATES-1:0] group_update_gate_n
);
    logic sleeping_any = 1'b0;
    initial begin
        reg_req = '0;
        group_update_gate_n = '1;
    end
    // ==========================================================
    // Bus cycles; idle address and data are inverted so no stale value helps
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        if (a == SLEEP_VOL_OFS) begin
            sleeping_any = (d[15:0] != 16'h0000);
        end
        // Stored copy is left alone while any channel sleeps
        if (a == SLEEP_NV_OFS && sleeping_any) begin
            return;
        end
        @(posedge mclk);
        reg_req.wr <= 1'b1;
        reg_req.addr <= a;
        reg_req.wdata <= d;
        @(posedge mclk);
        reg_req.wr <= 1'b0;
        reg_req.addr <= ~a;
        reg_req.wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_req.rd <= 1'b1;
        reg_req.addr <= a;
        @(posedge mclk);
        reg_req.rd <= 1'b0;
        reg_req.addr <= ~a;
        #1;
        d = rdata_ff;
    endtask : rd
    // Gate pins; both are held high when no synchronised update is wanted
    task automatic gate(input logic [NUM_GATES-1:0] g);
        @(posedge mclk);
        group_update_gate_n <= g;
    endtask : gate
endmodule : host_model

// [testbench/tb.sv]
// ==========================================================
// Self-checking bench for the latch and sleep control top.
// Assumes the host model drives every input except clock and reset.
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("Error at %0t: %s", $time, msg); end end
module tb
    import dac_ctl_pkg::*;
;
    logic mclk;
    logic rstn;
    reg_req_t reg_req;
    logic [31:0] rdata_ff;
    logic [NUM_GATES-1:0] group_update_gate_n;
    code_t [NUM_CH-1:0] wiper_ff;
    chan_ctrl_t [NUM_CH-1:0] chan_ctrl_ff;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] d;
    dac_latch_ctl i_dac_latch_ctl (.mclk(mclk), .rstn(rstn), .reg_req(reg_req),
        .rdata_ff(rdata_ff), .group_update_gate_n(group_update_gate_n),
        .wiper_ff(wiper_ff), .chan_ctrl_ff(chan_ctrl_ff));
    host_model i_host_model (.mclk(mclk), .reg_req(reg_req), .rdata_ff(rdata_ff),
        .group_update_gate_n(group_update_gate_n));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ==========================================================
    // Helpers
    function automatic code_t cv(input int c);
        return code_t'(256 + 273 * c);
    endfunction : cv
    function automatic chan_ctrl_t exp_ctrl(input logic [1:0] s, input logic [1:0] r);
        chan_ctrl_t c;
        c = '0;
        c.pd_1k = (s == SLEEP_1K);
        c.pd_100k = (s == SLEEP_100K);
        if (s == SLEEP_NORMAL) begin
            c.drive = 1'b1;
            c.amp_pwr = 1'b1;
            c.ladder_pwr = (r != REF_EXT_UNBUF);
            c.refbuf_pwr = r[0];
            c.bandgap_pwr = (r == REF_BANDGAP);
        end
        return c;
    endfunction : exp_ctrl
    task automatic results();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    // Hang guard, well above the length of the sequence below
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            $display("Error at %0t: timeout", $time);
            results();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        repeat (6) @(posedge mclk);
        i_host_model.rd(SLEEP_VOL_OFS, d);
        `CHK(d, 32'h0, "sleep bits after reset")
        for (int c = 0; c < NUM_CH; c++) begin
            `CHK(chan_ctrl_ff[c], exp_ctrl(2'h0, 2'h0), "ctrl after reset")
        end
        $display("Test reset done");
        // Gates high: codes land in registers but not in the output stage
        for (int c = 0; c < NUM_CH; c++) begin
            i_host_model.wr(CODE_BASE_OFS + 8'(4 * c), 32'(cv(c)));
        end
        repeat (5) @(posedge mclk);
        for (int c = 0; c < NUM_CH; c++) begin
            `CHK(wiper_ff[c], 12'h000, "wiper moved with gate high")
        end
        i_host_model.rd(CODE_BASE_OFS + 8'h14, d);
        `CHK(d, 32'(cv(5)), "code readback")
        i_host_model.gate(2'b10);
        repeat (2) @(posedge mclk);
        #1;
        for (int c = 0; c < CH_PER_GATE; c++) begin
            `CHK(wiper_ff[c], 12'h000, "group moved early")
        end
        @(posedge mclk);
        #1;
        for (int c = 0; c < NUM_CH; c++) begin
            `CHK(wiper_ff[c], (c < CH_PER_GATE) ? cv(c) : 12'h000, "group copy")
        end
        i_host_model.wr(CODE_BASE_OFS + 8'h08, 32'hABC);
        repeat (4) @(posedge mclk);
        `CHK(wiper_ff[2], 12'hABC, "wiper follows while low")
        i_host_model.wr(CODE_BASE_OFS + 8'h10, 32'h5A5);
        i_host_model.gate(2'b00);
        repeat (5) @(posedge mclk);
        `CHK(wiper_ff[4], 12'h5A5, "gate right after write")
        `CHK(wiper_ff[7], cv(7), "second group copy")
        i_host_model.rd(WIPER_BASE_OFS + 8'h10, d);
        `CHK(d, 32'h0000_05A5, "output stage readback")
        $display("Test gate done");
        // Sleep modes per channel, reference selects 01 10 11 00 on ch0..3
        i_host_model.wr(ENTRY_DLY_OFS, 32'h2);
        i_host_model.wr(EXIT_DLY_OFS, 32'h2);
        i_host_model.wr(REF_SEL_OFS, 32'h39);
        repeat (3) @(posedge mclk);
        for (int c = 0; c < 4; c++) begin
            `CHK(chan_ctrl_ff[c], exp_ctrl(2'h0, 2'(32'h39 >> (2 * c))), "ref power")
        end
        i_host_model.wr(SLEEP_VOL_OFS, 32'h39);
        repeat (2) @(posedge mclk);
        #1;
        `CHK(chan_ctrl_ff[0].drive, 1'b1, "drive dropped before entry delay")
        repeat (6) @(posedge mclk);
        for (int c = 0; c < NUM_CH; c++) begin
            `CHK(chan_ctrl_ff[c], exp_ctrl(2'(32'h39 >> (2 * c)), 2'(32'h39 >> (2 * c))),
                "sleep decode")
        end
        `CHK(wiper_ff[0], cv(0), "wiper kept in sleep")
        i_host_model.rd(STATUS_OFS, d);
        `CHK(d, 32'h0007_00F8, "status in sleep")
        i_host_model.rd(CODE_BASE_OFS + 8'h04, d);
        `CHK(d, 32'(cv(1)), "code kept in sleep")
        i_host_model.rd(REF_SEL_OFS, d);
        `CHK(d, 32'h39, "reference kept in sleep")
        i_host_model.wr(SLEEP_NV_OFS, 32'h5);
        i_host_model.wr(SLEEP_VOL_OFS, 32'h0);
        repeat (2) @(posedge mclk);
        #1;
        `CHK(chan_ctrl_ff[0].drive, 1'b0, "drive before exit delay")
        `CHK(chan_ctrl_ff[0].pd_1k, 1'b0, "pulldown kept on wake")
        repeat (5) @(posedge mclk);
        for (int c = 0; c < 4; c++) begin
            `CHK(chan_ctrl_ff[c], exp_ctrl(2'h0, 2'(32'h39 >> (2 * c))), "wake")
        end
        $display("Test sleep done");
        // Sleep request withdrawn inside the entry delay
        i_host_model.wr(SLEEP_VOL_OFS, 32'h1);
        i_host_model.wr(SLEEP_VOL_OFS, 32'h0);
        repeat (3) @(posedge mclk);
        #1;
        `CHK(chan_ctrl_ff[0].drive, 1'b1, "entry not cancelled")
        // Stored copy written while awake; volatile bits stay as written
        i_host_model.wr(SLEEP_NV_OFS, 32'h5);
        i_host_model.rd(SLEEP_NV_OFS, d);
        `CHK(d, 32'h5, "stored copy")
        i_host_model.rd(SLEEP_VOL_OFS, d);
        `CHK(d, 32'h0, "volatile bits moved")
        `CHK(chan_ctrl_ff[0].drive, 1'b1, "sleep without write")
        i_host_model.rd(8'h3C, d);
        `CHK(d, 32'h0, "unmapped read")
        $display("Test registers done");
        results();
    end
endmodule : tb
